// [logic/mcu_decode_pkg.sv]
// Shared constants and types for the instruction decode and timing block
package mcu_decode_pkg;
   // ==========================================================
   // Widths and timing
   localparam int WORD_W = 16;
   localparam int PC_W = 20;
   localparam int OSC_PER_ICYCLE = 4;
   localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_ICYCLE - 1);
   localparam logic [PC_W-1:0] PC_RESET = 20'h00000;
   // ==========================================================
   // Opcode encodings
   localparam logic [3:0] SECOND_MARK = 4'hf;
   localparam logic [3:0] BYTE_TOP_MAX = 4'h5;
   localparam logic [3:0] CTRL_SHORT = 4'h6;
   localparam logic [3:0] BIT_TOP_MIN = 4'h7;
   localparam logic [3:0] BIT_TOP_MAX = 4'hb;
   localparam logic [3:0] LIT_TOP_A = 4'hc;
   localparam logic [3:0] LIT_TOP_B = 4'hd;
   localparam logic [7:0] EXT_OP = 8'he8;
   localparam logic [7:0] DW_CALL = 8'hec;
   localparam logic [7:0] DW_COPY = 8'hed;
   localparam logic [7:0] DW_LOADPTR = 8'hee;
   localparam logic [7:0] DW_GOTO = 8'hef;
   // ==========================================================
   // Register port map and reset values
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_ICOUNT = 4'h2;
   localparam int RUN_BIT = 0;
   localparam int EXT_BIT = 1;
   localparam int ERR_BIT = 4;
   localparam logic [7:0] CTRL_RESET = 8'h01;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   typedef enum logic [2:0] {CLS_BYTE, CLS_BIT, CLS_LIT, CLS_CTRL, CLS_EXT, CLS_NOP} cls_e;
   typedef enum logic [1:0] {ST_FIRST, ST_SECOND} seq_e;
endpackage : mcu_decode_pkg

// [logic/dec_if.sv]
// Carrier between the sequencer and the field splitter
`timescale 1ns/100ps
interface dec_if;
   logic [15:0] word;
   logic ext_en;
   mcu_decode_pkg::cls_e cls;
   logic dbl;
   logic dbl_branch;
   logic nop;
   logic dest_file;
   logic bank_sel;
   logic [7:0] file_addr;
   logic [2:0] bit_sel;
   logic [7:0] lit;
   logic [1:0] ptr_sel;
   logic [1:0] tbl_mode;
   logic call_mode;
   logic [2:0] ext_idx;
   modport seq (output word, ext_en, input cls, dbl, dbl_branch, nop, dest_file, bank_sel,
      file_addr, bit_sel, lit, ptr_sel, tbl_mode, call_mode, ext_idx);
   modport split (input word, ext_en, output cls, dbl, dbl_branch, nop, dest_file, bank_sel,
      file_addr, bit_sel, lit, ptr_sel, tbl_mode, call_mode, ext_idx);
endinterface : dec_if

// [logic/field_splitter.sv]
// Splits one program word into category and operand fields
`timescale 1ns/100ps
module field_splitter (
   dec_if.split bus
);
   // ==========================================================
   // Category
   wire [3:0] top_w = bus.word[15:12];
   wire [7:0] op_w = bus.word[15:8];
   wire second_w = top_w == mcu_decode_pkg::SECOND_MARK;
   wire ext_w = op_w == mcu_decode_pkg::EXT_OP;
   wire byte_w = top_w <= mcu_decode_pkg::BYTE_TOP_MAX;
   wire bit_w = (top_w >= mcu_decode_pkg::BIT_TOP_MIN) && (top_w <= mcu_decode_pkg::BIT_TOP_MAX);
   wire lit_w = (top_w == mcu_decode_pkg::LIT_TOP_A) || (top_w == mcu_decode_pkg::LIT_TOP_B);
   // Extended ops only exist while enabled; otherwise they fall through as no-ops
   assign bus.nop = second_w | (ext_w & ~bus.ext_en); // RULE10
   assign bus.cls = bus.nop ? mcu_decode_pkg::CLS_NOP :
                    ext_w ? mcu_decode_pkg::CLS_EXT :
                    byte_w ? mcu_decode_pkg::CLS_BYTE :
                    bit_w ? mcu_decode_pkg::CLS_BIT :
                    lit_w ? mcu_decode_pkg::CLS_LIT : mcu_decode_pkg::CLS_CTRL; // RULE1
   assign bus.dbl_branch = (op_w == mcu_decode_pkg::DW_CALL) || (op_w == mcu_decode_pkg::DW_GOTO);
   assign bus.dbl = bus.dbl_branch || (op_w == mcu_decode_pkg::DW_COPY) ||
                    (op_w == mcu_decode_pkg::DW_LOADPTR); // RULE2
   // ==========================================================
   // Operand fields
   assign bus.file_addr = bus.word[7:0]; // RULE3 RULE4 RULE16
   assign bus.dest_file = byte_w & bus.word[9]; // RULE5
   assign bus.bank_sel = bus.word[8]; // RULE15
   assign bus.bit_sel = bus.word[11:9]; // RULE6
   assign bus.lit = bus.word[7:0]; // RULE7
   assign bus.ptr_sel = bus.word[5:4];
   assign bus.tbl_mode = bus.word[1:0]; // RULE17
   assign bus.call_mode = bus.word[0]; // RULE8
   assign bus.ext_idx = bus.word[7:5];
endmodule : field_splitter

// [logic/mcu_instruction_decode_timing.sv]
// Instruction fetch, field decode and instruction-cycle timing
//
// Functional notes
// (RULE1) Decode core ops plus eight extended ops for software-stack code.
// (RULE2) Most instructions are one 16-bit word; four take two words.
// (RULE3) A single word splits into an opcode and operand fields.
// (RULE4) Byte ops carry file address, destination bit and access bit.
// (RULE5) Destination zero sends result to working_register, one to the file.
// (RULE6) Bit ops carry file address, bit number and access bit.
// (RULE7) Literal ops carry a constant, maybe a pointer select, or nothing.
// (RULE8) Control ops carry address, call/return mode, table mode, or nothing.
// (RULE9) A second word has its top four bits all ones.
// (RULE10) A second word executed alone acts as a no-operation.
// (RULE11) Single words take one cycle; two when a test is true or PC jumps.
// (RULE12) Double-word instructions take two instruction cycles.
// (RULE13) One instruction cycle is four oscillator periods.
// (RULE14) A taken two-word branch takes three instruction cycles.
// (RULE15) Access bit zero uses access bank; one uses bank_select_register.
// (RULE16) File address is eight bits; bit select names bits 0 to 7.
// (RULE17) Table mode: no change, post-inc, post-dec or pre-inc of table_pointer.
// (RULE18) Hold first word until second is fetched, then issue both and skip past.
`timescale 1ns/100ps
module mcu_instruction_decode_timing (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [15:0] pm_data_in,
   input wire logic taken_in,
   input wire logic [19:0] target_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [19:0] pm_addr_out,
   output logic icycle_out,
   output logic exec_valid_out,
   output logic exec_nop_out,
   output logic [2:0] exec_cls_out,
   output logic [31:0] exec_word_out,
   output logic dest_file_out,
   output logic bank_sel_out,
   output logic [7:0] file_addr_out,
   output logic [2:0] bit_sel_out,
   output logic [7:0] lit_out,
   output logic [1:0] ptr_sel_out,
   output logic [1:0] tbl_mode_out,
   output logic call_mode_out,
   output logic [2:0] ext_idx_out,
   output logic [7:0] reg_rdata_out
);
   // ==========================================================
   // State
   logic [1:0] phase_q;
   mcu_decode_pkg::seq_e state_q, state_d;
   logic [19:0] pc_q, pc_d;
   logic [15:0] hold_q;
   logic armed_q, armed_d;
   logic err_q;
   logic [7:0] ctrl_q;
   logic [7:0] count_q;
   logic icyc_q, valid_q, nop_q;
   mcu_decode_pkg::cls_e cls_q;
   logic [31:0] word_q;
   logic dest_q, bank_q, call_q;
   logic [7:0] faddr_q, lit_q, rdata_q;
   logic [2:0] bit_q, ext_q;
   logic [1:0] ptr_q, tbl_q;

   dec_if dif ();
   field_splitter u_split (
      .bus(dif)
   );

   // ==========================================================
   // Sequencing decisions, all taken on the last phase
   wire tick_w = phase_q == mcu_decode_pkg::PHASE_LAST; // RULE13
   wire act_w = tick_w & ctrl_q[mcu_decode_pkg::RUN_BIT];
   wire in_second_w = state_q == mcu_decode_pkg::ST_SECOND;
   // Branch outcome arrives during the cycle after issue, so the prefetched word is dropped
   wire flush_w = armed_q & taken_in; // RULE11 RULE14
   wire start_dbl_w = ~flush_w & ~in_second_w & dif.dbl; // RULE18
   wire issue_w = act_w & ~start_dbl_w;
   wire nop_issue_w = flush_w | (~in_second_w & dif.nop); // RULE10
   wire bad_second_w = act_w & ~flush_w & in_second_w &
                       (pm_data_in[15:12] != mcu_decode_pkg::SECOND_MARK); // RULE9
   wire [31:0] word_w = flush_w ? 32'h00000000 :
                        in_second_w ? {hold_q, pm_data_in} : {16'h0000, pm_data_in};

   assign dif.word = in_second_w ? hold_q : pm_data_in;
   assign dif.ext_en = ctrl_q[mcu_decode_pkg::EXT_BIT];

   always_comb begin
      state_d = state_q;
      case (state_q)
         mcu_decode_pkg::ST_FIRST: begin
            if (act_w & start_dbl_w) begin
               state_d = mcu_decode_pkg::ST_SECOND; // RULE12
            end
         end
         mcu_decode_pkg::ST_SECOND: begin
            if (act_w) begin
               state_d = mcu_decode_pkg::ST_FIRST;
            end
         end
         default: state_d = mcu_decode_pkg::ST_FIRST;
      endcase
   end
   // Second word address first, then past both words
   assign pc_d = ~act_w ? pc_q : flush_w ? target_in : pc_q + 20'h00001; // RULE18
   assign armed_d = act_w ? (issue_w & ~nop_issue_w) : armed_q; // RULE11

   // ==========================================================
   // Register port
   wire wr_ctrl_w = reg_wr_in & (reg_addr_in == mcu_decode_pkg::REG_CTRL);
   wire wr_status_w = reg_wr_in & (reg_addr_in == mcu_decode_pkg::REG_STATUS);
   wire wr_count_w = reg_wr_in & (reg_addr_in == mcu_decode_pkg::REG_ICOUNT);
   wire [7:0] status_w = {3'h0, err_q, 1'b0, armed_q, in_second_w, act_w};
   wire [7:0] rsel_w = (reg_addr_in == mcu_decode_pkg::REG_CTRL) ? ctrl_q :
                       (reg_addr_in == mcu_decode_pkg::REG_STATUS) ? status_w :
                       (reg_addr_in == mcu_decode_pkg::REG_ICOUNT) ? count_q : 8'h00;
   // Hardware set beats a software clear in the same cycle
   wire err_d = bad_second_w | (err_q & ~(wr_status_w & reg_wdata_in[mcu_decode_pkg::ERR_BIT]));
   wire [7:0] count_d = wr_count_w ? mcu_decode_pkg::COUNT_RESET :
                        act_w ? count_q + 8'h01 : count_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         phase_q <= 2'h0;
         state_q <= mcu_decode_pkg::ST_FIRST;
         pc_q <= mcu_decode_pkg::PC_RESET;
         armed_q <= 1'b0;
         icyc_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         phase_q <= phase_q + 2'h1; // RULE13
         state_q <= state_d;
         pc_q <= pc_d;
         armed_q <= armed_d;
         icyc_q <= tick_w;
         valid_q <= issue_w; // RULE11 RULE12
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ctrl_q <= mcu_decode_pkg::CTRL_RESET;
         count_q <= mcu_decode_pkg::COUNT_RESET;
         err_q <= 1'b0;
         rdata_q <= 8'h00;
         hold_q <= 16'h0000;
      end else begin
         ctrl_q <= wr_ctrl_w ? {6'h00, reg_wdata_in[1:0]} : ctrl_q;
         count_q <= count_d;
         err_q <= err_d;
         rdata_q <= reg_rd_in ? rsel_w : 8'h00;
         hold_q <= (act_w & start_dbl_w) ? pm_data_in : hold_q; // RULE18
      end
   end

   // ==========================================================
   // Issued instruction fields, held until the next issue
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         nop_q <= 1'b0;
         cls_q <= mcu_decode_pkg::CLS_NOP;
         word_q <= 32'h00000000;
         dest_q <= 1'b0;
         bank_q <= 1'b0;
         faddr_q <= 8'h00;
         bit_q <= 3'h0;
         lit_q <= 8'h00;
         ptr_q <= 2'h0;
         tbl_q <= 2'h0;
         call_q <= 1'b0;
         ext_q <= 3'h0;
      end else if (issue_w) begin
         nop_q <= nop_issue_w;
         cls_q <= nop_issue_w ? mcu_decode_pkg::CLS_NOP : dif.cls; // RULE1 RULE3
         word_q <= word_w;
         dest_q <= dif.dest_file; // RULE5
         bank_q <= dif.bank_sel; // RULE15
         faddr_q <= dif.file_addr; // RULE4 RULE16
         bit_q <= dif.bit_sel; // RULE6
         lit_q <= dif.lit; // RULE7
         ptr_q <= dif.ptr_sel;
         tbl_q <= dif.tbl_mode; // RULE17
         call_q <= dif.call_mode; // RULE8
         ext_q <= dif.ext_idx;
      end
   end

   assign pm_addr_out = pc_q;
   assign icycle_out = icyc_q;
   assign exec_valid_out = valid_q;
   assign exec_nop_out = nop_q;
   assign exec_cls_out = cls_q;
   assign exec_word_out = word_q;
   assign dest_file_out = dest_q;
   assign bank_sel_out = bank_q;
   assign file_addr_out = faddr_q;
   assign bit_sel_out = bit_q;
   assign lit_out = lit_q;
   assign ptr_sel_out = ptr_q;
   assign tbl_mode_out = tbl_q;
   assign call_mode_out = call_q;
   assign ext_idx_out = ext_q;
   assign reg_rdata_out = rdata_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_cycle_four_osc: assert property ( // RULE13
      icycle_out |=> !icycle_out [*3] ##1 icycle_out)
      else $error("instruction cycle is not four clocks");

   a_second_alone_nop: assert property ( // RULE10
      act_w && !flush_w && !in_second_w && pm_data_in[15:12] == 4'hf
      |=> exec_valid_out && exec_nop_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_NOP))
      else $error("lone second word not issued as no-op");

   a_dest_route: assert property ( // RULE5
      exec_valid_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_BYTE)
      |-> dest_file_out == exec_word_out[9] && file_addr_out == exec_word_out[7:0])
      else $error("byte destination does not follow its bit");

   a_bit_fields: assert property ( // RULE6
      exec_valid_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_BIT)
      |-> bit_sel_out == exec_word_out[11:9] && bank_sel_out == exec_word_out[8])
      else $error("bit select or access bit wrong");

   a_dbl_two_cycles: assert property ( // RULE12
      act_w && start_dbl_w && ctrl_q[0]
      |=> !exec_valid_out [*4] ##1 (exec_valid_out && exec_word_out[31:16] == $past(hold_q)))
      else $error("double word not issued one cycle later");

   a_pc_past_both: assert property ( // RULE18
      act_w && start_dbl_w ##4 act_w && !taken_in |=> pm_addr_out == $past(pc_q, 5) + 20'h2)
      else $error("program counter not past both words");

   a_taken_flush: assert property ( // RULE11
      act_w && armed_q && taken_in
      |=> exec_valid_out && exec_nop_out && pm_addr_out == $past(target_in))
      else $error("taken branch not followed by a no-op cycle");

   a_ext_gated: assert property ( // RULE1
      exec_valid_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_EXT)
      |-> $past(ctrl_q[mcu_decode_pkg::EXT_BIT]))
      else $error("extended op issued while disabled");

   a_second_mark: assert property ( // RULE9
      act_w && in_second_w && pm_data_in[15:12] != 4'hf |=> err_q)
      else $error("malformed second word not flagged");

   // Field routing and step checks
   a_flush_word_zero: assert property ( // RULE11
      act_w && armed_q && taken_in |=> exec_word_out == 32'h00000000)
      else $error("flushed slot carries a word");

   a_pc_step: assert property ( // RULE11
      act_w && !flush_w |=> pm_addr_out == $past(pc_q) + 20'h00001)
      else $error("program counter did not step by one");

   a_dbl_word_pair: assert property ( // RULE18
      act_w && in_second_w
      |=> exec_valid_out && exec_word_out == {$past(hold_q), $past(pm_data_in)})
      else $error("double word not issued as a pair");

   a_valid_on_act: assert property ( // RULE13
      exec_valid_out |-> $past(act_w))
      else $error("issue not on an instruction cycle boundary");

   a_taken_dbl_three: assert property ( // RULE14
      act_w && in_second_w && dif.dbl_branch ##4 act_w && taken_in
      |=> exec_valid_out && exec_nop_out)
      else $error("taken two-word branch lacks its third cycle");

   a_byte_bank: assert property ( // RULE15
      exec_valid_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_BYTE)
      |-> bank_sel_out == exec_word_out[8])
      else $error("byte access bit wrong");

   a_lit_fields: assert property ( // RULE7
      exec_valid_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_LIT)
      |-> lit_out == exec_word_out[7:0] && ptr_sel_out == exec_word_out[5:4])
      else $error("literal or pointer select wrong");

   a_ctrl_fields: assert property ( // RULE8 RULE17
      exec_valid_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_CTRL) &&
      exec_word_out[31:16] == 16'h0000
      |-> tbl_mode_out == exec_word_out[1:0] && call_mode_out == exec_word_out[0])
      else $error("table or call mode wrong");

   a_bit_addr: assert property ( // RULE16
      exec_valid_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_BIT)
      |-> file_addr_out == exec_word_out[7:0])
      else $error("bit op file address wrong");

   a_ext_index: assert property ( // RULE1
      exec_valid_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_EXT)
      |-> ext_idx_out == exec_word_out[7:5])
      else $error("extended index wrong");

   c_dbl_issue: cover property (act_w && start_dbl_w ##5 exec_valid_out);
   c_dbl_taken: cover property (act_w && in_second_w ##4 act_w && armed_q && taken_in);
   c_ext_issue: cover property (exec_valid_out && exec_cls_out == 3'(mcu_decode_pkg::CLS_EXT));
   c_lone_second: cover property (exec_valid_out && exec_nop_out && !$past(flush_w, 1));
   c_bad_second: cover property (act_w && in_second_w && pm_data_in[15:12] != 4'hf);
endmodule : mcu_instruction_decode_timing

// [verification/prog_mem.sv]
// Program memory model that feeds instruction words to the decoder
`timescale 1ns/100ps
module prog_mem (
   input wire logic [19:0] addr_in,
   output logic [15:0] data_out
);
   logic [15:0] words [0:63];
   // ==========================================================
   // Read port
   // Combinational read, so the word is settled long before the fetch edge
   assign data_out = words[addr_in[5:0]];
endmodule : prog_mem

// [verification/mcu_instruction_decode_timing_tb.sv]
// Self-checking bench for the instruction decode and timing block
`timescale 1ns/100ps
module mcu_instruction_decode_timing_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic taken = 1'b0;
   logic [19:0] target = 20'h00000;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] pm_data;
   logic [19:0] pm_addr;
   logic icycle_out, exec_valid_out, exec_nop_out, dest_file_out, bank_sel_out, call_mode_out;
   logic [2:0] exec_cls_out, bit_sel_out, ext_idx_out;
   logic [31:0] exec_word_out;
   logic [7:0] file_addr_out, lit_out, reg_rdata_out;
   logic [1:0] ptr_sel_out, tbl_mode_out;
   int err_count = 0;
   int n_tests = 0;
   int n_issue = 0;
   int clk_cnt = 0;
   int last_t = 0;
   int last_ic = 0;
   // Expected issue stream: word and class per issued slot, class 5 is a no-operation
   logic [31:0] exp_word [0:15] = '{32'h03a5, 32'h2c3c, 32'h7b81, 32'hc0e7, 32'h6000, 32'h6001,
      32'h6002, 32'h6003, 32'hed12f345, 32'h0, 32'h0, 32'h0101, 32'h0, 32'hef40f001, 32'h0,
      32'he8e0};
   logic [2:0] exp_cls [0:15] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h5,
      3'h5, 3'h0, 3'h5, 3'h3, 3'h5, 3'h4};

   mcu_instruction_decode_timing dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
      .pm_data_in(pm_data), .taken_in(taken), .target_in(target), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .pm_addr_out(pm_addr),
      .icycle_out(icycle_out), .exec_valid_out(exec_valid_out), .exec_nop_out(exec_nop_out),
      .exec_cls_out(exec_cls_out), .exec_word_out(exec_word_out),
      .dest_file_out(dest_file_out), .bank_sel_out(bank_sel_out),
      .file_addr_out(file_addr_out), .bit_sel_out(bit_sel_out), .lit_out(lit_out),
      .ptr_sel_out(ptr_sel_out), .tbl_mode_out(tbl_mode_out), .call_mode_out(call_mode_out),
      .ext_idx_out(ext_idx_out), .reg_rdata_out(reg_rdata_out));
   prog_mem pm (.addr_in(pm_addr), .data_out(pm_data));

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // Checking and register access
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", 32'(reg_rdata_out), 32'(exp));
   endtask : reg_read

   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done

   // ==========================================================
   // Execution unit stand-in: reports a taken branch in the cycle after its issue
   always @(posedge sys_clk) begin
      clk_cnt <= clk_cnt + 1;
      if (exec_valid_out) begin
         taken <= (exec_word_out === 32'h00000101) || (exec_word_out[31:24] === 8'hef);
         target <= (exec_word_out[31:24] === 8'hef) ? 20'h00030 : 20'h00020;
      end
   end

   // ==========================================================
   // Issue and timing monitor
   always @(posedge sys_clk) begin
      if (rst_n && icycle_out) begin
         if (last_ic != 0) check("icycle gap", 32'(clk_cnt - last_ic), 32'h4);
         last_ic = clk_cnt;
      end
      if (rst_n && exec_valid_out && n_issue < 16) begin
         check("cls", 32'(exec_cls_out), 32'(exp_cls[n_issue]));
         check("nop", 32'(exec_nop_out), 32'(exp_cls[n_issue] == 3'h5));
         if (n_issue != 9 && n_issue != 10) check("word", exec_word_out, exp_word[n_issue]);
         if (n_issue > 0) check("gap", 32'(clk_cnt - last_t),
            (n_issue == 8 || n_issue == 13) ? 32'h8 : 32'h4);
         case (n_issue)
            0, 1: begin
               check("dest", 32'(dest_file_out), 32'(n_issue == 0));
               check("bank", 32'(bank_sel_out), 32'(n_issue == 0));
               check("faddr", 32'(file_addr_out), n_issue == 0 ? 32'ha5 : 32'h3c);
            end
            2: begin
               check("bitsel", 32'(bit_sel_out), 32'h5);
               check("faddr", 32'(file_addr_out), 32'h81);
            end
            3: begin
               check("lit", 32'(lit_out), 32'he7);
               check("ptr", 32'(ptr_sel_out), 32'h2);
            end
            4, 5, 6, 7: begin
               check("tbl", 32'(tbl_mode_out), 32'(n_issue - 4));
               check("call", 32'(call_mode_out), 32'(n_issue % 2));
            end
            8: check("pc", 32'(pm_addr), 32'ha);
            12: check("pc", 32'(pm_addr), 32'h20);
            14: check("pc", 32'(pm_addr), 32'h30);
            15: check("ext", 32'(ext_idx_out), 32'h7);
            default: ;
         endcase
         last_t = clk_cnt;
      end
      if (rst_n && exec_valid_out) n_issue++;
   end

   // ==========================================================
   // Main sequence
   initial begin
      for (int i = 0; i < 64; i++) pm.words[i] = 16'hffff;
      pm.words[0] = 16'h03a5;
      pm.words[1] = 16'h2c3c;
      pm.words[2] = 16'h7b81;
      pm.words[3] = 16'hc0e7;
      for (int i = 0; i < 4; i++) pm.words[4 + i] = 16'h6000 + 16'(i);
      pm.words[8] = 16'hed12;
      pm.words[9] = 16'hf345;
      pm.words[10] = 16'hf0aa;
      pm.words[11] = 16'he8a0;
      pm.words[12] = 16'h0101;
      pm.words[32] = 16'hef40;
      pm.words[33] = 16'hf001;
      pm.words[48] = 16'he8e0;
      pm.words[49] = 16'hed00;
      pm.words[50] = 16'h0000;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      reg_read(4'h0, 8'h01);
      reg_read(4'h2, 8'h00);
      reg_read(4'h7, 8'h00);
      $display("reset test done");
      wait (n_issue >= 12);
      reg_write(4'h0, 8'h03);
      wait (n_issue >= 16);
      reg_read(4'h0, 8'h03);
      reg_read(4'h2, 8'h13);
      $display("issue test done");
      wait (n_issue >= 17);
      reg_read(4'h1, 8'h14);
      reg_write(4'h1, 8'h10);
      reg_read(4'h1, 8'h00);
      $display("status test done");
      test_done();
   end

   // Whole run is under 200 clocks; a hang is cut off well after that
   initial begin
      repeat (3000) @(posedge sys_clk);
      err_count++;
      test_done();
   end
endmodule : mcu_instruction_decode_timing_tb
